// *** shared/mii_regs.svh ***
// Constants for the MII MAC-side block: widths, buffer depth, nibble idle code.
// Assumes nothing; included by bare name wherever a constant is needed.
`ifndef MII_REGS_SVH
`define MII_REGS_SVH

`define MII_NIBBLE_W    4
`define MII_BYTE_W      8
`define MII_WORD_W      (`MII_BYTE_W + 2)
`define MII_FIFO_DEPTH  16
`define MII_NIBBLE_IDLE 4'h0

`endif

// *** shared/mii_pkg.sv ***
// Types shared by the MII MAC-side block.
// Assumes mii_regs.svh supplies the widths.
`include "mii_regs.svh"

package mii_pkg;

  // One buffered byte with its frame marks
  typedef struct packed {
    logic                   last;
    logic                   err;
    logic [`MII_BYTE_W-1:0] data;
  } mii_word_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_LOW,
    TX_HIGH,
    TX_GAP,
    TX_FLUSH
  } mii_tx_state_t;

endpackage : mii_pkg

// *** shared/mii_stream_if.sv ***
// Valid/ready word stream between the block's own modules.
// Assumes both ends sit on one clock; the interface itself is unclocked.
`timescale 1ns/10ps

interface mii_stream_if #(parameter int W = 10);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mii_stream_if

// *** hw/mii_sync.sv ***
// Two-flop synchroniser for independent level bits.
// Assumes each bit is a level that may change at any time.
`timescale 1ns/10ps

module mii_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  // First stage feeds only the second
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : mii_sync

// *** hw/mii_fifo.sv ***
// Dual-clock word FIFO with gray-coded pointers.
// Assumes DEPTH is a power of two, at least 4, and WIDTH matches both streams.
`timescale 1ns/10ps
`include "mii_regs.svh"

module mii_fifo import mii_pkg::*; #(
  parameter int WIDTH = `MII_WORD_W,
  parameter int DEPTH = `MII_FIFO_DEPTH
) (
  input  wire logic  wr_clk_i,
  input  wire logic  wr_reset_n_i,
  input  wire logic  rd_clk_i,
  input  wire logic  rd_reset_n_i,
  mii_stream_if.snk  wr,
  mii_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  logic [AW:0]      wbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rbin;
  logic [AW:0]      rgray;
  logic [AW:0]      wgray_s;
  logic [AW:0]      rgray_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;
  logic             wpush;
  logic             rpop;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  // Full when write is a lap ahead: top two gray bits inverted
  assign full  = (wgray == {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
  assign empty = (rgray == wgray_s);
  assign wpush = wr.valid && !full;
  assign rpop  = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rbin[AW-1:0]];

  always_ff @(posedge wr_clk_i or negedge wr_reset_n_i) begin
    if (!wr_reset_n_i) begin
      wbin  <= '0;
      wgray <= '0;
    end else if (wpush) begin
      wbin  <= wbin + 1'b1;
      wgray <= to_gray(wbin + 1'b1);
    end
  end

  always_ff @(posedge wr_clk_i) begin
    if (wpush) begin
      mem[wbin[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge rd_clk_i or negedge rd_reset_n_i) begin
    if (!rd_reset_n_i) begin
      rbin  <= '0;
      rgray <= '0;
    end else if (rpop) begin
      rbin  <= rbin + 1'b1;
      rgray <= to_gray(rbin + 1'b1);
    end
  end

  mii_sync #(.WIDTH(AW + 1)) u_rsync (
    .clk_i     (wr_clk_i),
    .reset_n_i (wr_reset_n_i),
    .d_i       (rgray),
    .q_o       (rgray_s)
  );

  mii_sync #(.WIDTH(AW + 1)) u_wsync (
    .clk_i     (rd_clk_i),
    .reset_n_i (rd_reset_n_i),
    .d_i       (wgray),
    .q_o       (wgray_s)
  );
endmodule : mii_fifo

// *** hw/mii_mac_phy_interface.sv ***
// MAC side of a 10/100 media independent interface: nibble transmit and
// receive paths on the PHY's clocks, byte streams on mclk_i.
// Assumes the PHY supplies both link clocks and meets their timing.
`timescale 1ns/10ps
`include "mii_regs.svh"

// What this block does
// - Transmit and receive move four-bit nibbles on separate independent paths.
// - Transmit enable is high exactly while nibbles are presented, on transmit clock.
// - Transmit nibble changes only on transmit clock, one nibble per period.
// - Each valid receive period carries four data bits, captured on receive clock.
// - Carrier sense is asynchronous and is synchronised before use.
module mii_mac_phy_interface import mii_pkg::*; #(
  parameter int FIFO_DEPTH = `MII_FIFO_DEPTH
) (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   mii_transmit_clock_in_i,
  input  wire logic                   mii_receive_clock_in_i,
  output logic                        mii_transmit_enable_out_o,
  output logic [`MII_NIBBLE_W-1:0]    mii_transmit_nibble_out_o,
  output logic                        mii_transmit_error_out_o,
  input  wire logic                   mii_receive_valid_in_i,
  input  wire logic [`MII_NIBBLE_W-1:0] mii_receive_nibble_in_i,
  input  wire logic                   mii_receive_error_in_i,
  input  wire logic                   mii_carrier_sense_in_i,
  input  wire logic                   mii_collision_in_i,
  input  wire logic                   tx_valid_i,
  input  wire logic [`MII_BYTE_W-1:0] tx_data_i,
  input  wire logic                   tx_last_i,
  input  wire logic                   tx_error_i,
  output logic                        tx_ready_o,
  output logic                        rx_valid_o,
  output logic [`MII_BYTE_W-1:0]      rx_data_o,
  output logic                        rx_last_o,
  output logic                        rx_error_o,
  input  wire logic                   rx_ready_i,
  output logic                        carrier_sense_o,
  output logic                        collision_o,
  output logic                        tx_underrun_o,
  output logic                        rx_overflow_o
);
  localparam int NW = `MII_NIBBLE_W;
  localparam int BW = `MII_BYTE_W;

  logic rst_tx_n;
  logic rst_rx_n;

  mii_stream_if #(.W(`MII_WORD_W)) tx_w ();
  mii_stream_if #(.W(`MII_WORD_W)) tx_r ();
  mii_stream_if #(.W(`MII_WORD_W)) rx_w ();
  mii_stream_if #(.W(`MII_WORD_W)) rx_r ();

  // Release of each link domain's reset is timed on that domain's clock
  mii_sync #(.WIDTH(1)) u_trst (
    .clk_i     (mii_transmit_clock_in_i),
    .reset_n_i (reset_n_i),
    .d_i       (1'b1),
    .q_o       (rst_tx_n)
  );

  mii_sync #(.WIDTH(1)) u_rrst (
    .clk_i     (mii_receive_clock_in_i),
    .reset_n_i (reset_n_i),
    .d_i       (1'b1),
    .q_o       (rst_rx_n)
  );

  // User side of the transmit buffer
  assign tx_w.valid = tx_valid_i;
  assign tx_w.data  = {tx_last_i, tx_error_i, tx_data_i};
  assign tx_ready_o = tx_w.ready;

  mii_fifo #(.WIDTH(`MII_WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .wr_clk_i     (mclk_i),
    .wr_reset_n_i (reset_n_i),
    .rd_clk_i     (mii_transmit_clock_in_i),
    .rd_reset_n_i (rst_tx_n),
    .wr           (tx_w),
    .rd           (tx_r)
  );

  // Transmit path, clocked by the PHY's transmit clock
  mii_tx_state_t        tx_state;
  mii_tx_state_t        next_state;
  mii_word_t            tx_word;
  mii_word_t            tx_hold;
  logic                 tx_take;
  logic                 tx_en;
  logic                 next_en;
  logic [NW-1:0]        tx_nib;
  logic [NW-1:0]        next_nib;
  logic                 tx_er;
  logic                 next_er;
  logic                 tx_under_tog;
  logic [NW-1:0]        tx_low_nib;
  logic [NW-1:0]        tx_high_nib;

  assign tx_word     = mii_word_t'(tx_r.data);
  assign tx_low_nib  = tx_word.data[NW-1:0];
  assign tx_high_nib = tx_hold.data[BW-1:NW];
  assign tx_r.ready  = tx_take;

  always_comb begin
    next_state = tx_state;
    next_en    = 1'b0;
    next_nib   = `MII_NIBBLE_IDLE;
    next_er    = 1'b0;
    tx_take    = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        tx_take = 1'b1;
        if (tx_r.valid) begin
          next_en    = 1'b1;
          next_nib   = tx_low_nib;
          next_er    = tx_word.err;
          next_state = TX_HIGH;
        end
      end
      TX_LOW: begin
        tx_take = 1'b1;
        next_en = 1'b1;
        if (tx_r.valid) begin
          next_nib   = tx_low_nib;
          next_er    = tx_word.err;
          next_state = TX_HIGH;
        end else begin
          next_er    = 1'b1;
          next_state = TX_FLUSH;
        end
      end
      TX_HIGH: begin
        next_en    = 1'b1;
        next_nib   = tx_high_nib;
        next_er    = tx_hold.err;
        next_state = tx_hold.last ? TX_GAP : TX_LOW;
      end
      // Enable low at least one period between frames
      TX_GAP: begin
        next_state = TX_IDLE;
      end
      // Drop the rest of an underrun frame
      TX_FLUSH: begin
        tx_take = 1'b1;
        if (tx_r.valid && tx_word.last) begin
          next_state = TX_IDLE;
        end
      end
      default: begin
        next_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mii_transmit_clock_in_i or negedge rst_tx_n) begin
    if (!rst_tx_n) begin
      tx_state <= TX_IDLE;
    end else begin
      tx_state <= next_state;
    end
  end

  always_ff @(posedge mii_transmit_clock_in_i or negedge rst_tx_n) begin
    if (!rst_tx_n) begin
      tx_hold <= '0;
    end else if (tx_take && tx_r.valid) begin
      tx_hold <= tx_word;
    end
  end

  // enable and nibble from transmit-clock flops
  always_ff @(posedge mii_transmit_clock_in_i or negedge rst_tx_n) begin
    if (!rst_tx_n) begin
      tx_en  <= 1'b0;
      tx_nib <= `MII_NIBBLE_IDLE;
      tx_er  <= 1'b0;
    end else begin
      tx_en  <= next_en;
      tx_nib <= next_nib;
      tx_er  <= next_er;
    end
  end

  always_ff @(posedge mii_transmit_clock_in_i or negedge rst_tx_n) begin
    if (!rst_tx_n) begin
      tx_under_tog <= 1'b0;
    end else if (tx_state == TX_LOW && !tx_r.valid) begin
      tx_under_tog <= ~tx_under_tog;
    end
  end

  assign mii_transmit_enable_out_o = tx_en;
  assign mii_transmit_nibble_out_o = tx_nib;
  assign mii_transmit_error_out_o  = tx_er;

  // enable drops one period after last nibble
  a_txen_frame_end: assert property (
    @(posedge mii_transmit_clock_in_i) disable iff (!rst_tx_n)
    (tx_state == TX_HIGH && tx_hold.last) |=> tx_en ##1 !tx_en)
    else $error("transmit enable did not end after last nibble");

  a_tx_idle_quiet: assert property (
    @(posedge mii_transmit_clock_in_i) disable iff (!rst_tx_n)
    !tx_en |-> (tx_nib == `MII_NIBBLE_IDLE) && !tx_er)
    else $error("transmit lines not idle while enable low");

  a_tx_high_nibble: assert property (
    @(posedge mii_transmit_clock_in_i) disable iff (!rst_tx_n)
    (tx_state == TX_HIGH) |=> tx_en && (tx_nib == $past(tx_high_nib)))
    else $error("high nibble not presented after low nibble");

  a_tx_low_nibble: assert property (
    @(posedge mii_transmit_clock_in_i) disable iff (!rst_tx_n)
    ((tx_state == TX_IDLE || tx_state == TX_LOW) && tx_r.valid)
      |=> tx_en && (tx_nib == $past(tx_low_nib)))
    else $error("low nibble not presented when byte taken");

  // Receive path, clocked by the PHY's receive clock
  logic          rx_dv_q;
  logic [NW-1:0] rx_nib_q;
  logic          rx_er_q;
  logic          rx_half;
  logic [NW-1:0] rx_low;
  logic [BW-1:0] rx_pend;
  logic          rx_pend_v;
  logic          rx_ferr;
  logic          rx_ovf;
  logic          rx_ovf_tog;
  logic          rx_push;
  mii_word_t     rx_push_word;

  // pins sampled once, already on their own clock
  always_ff @(posedge mii_receive_clock_in_i or negedge rst_rx_n) begin
    if (!rst_rx_n) begin
      rx_dv_q  <= 1'b0;
      rx_nib_q <= `MII_NIBBLE_IDLE;
      rx_er_q  <= 1'b0;
    end else begin
      rx_dv_q  <= mii_receive_valid_in_i;
      rx_nib_q <= mii_receive_nibble_in_i;
      rx_er_q  <= mii_receive_error_in_i;
    end
  end

  always_ff @(posedge mii_receive_clock_in_i or negedge rst_rx_n) begin
    if (!rst_rx_n) begin
      rx_half   <= 1'b0;
      rx_low    <= `MII_NIBBLE_IDLE;
      rx_pend   <= '0;
      rx_pend_v <= 1'b0;
    end else if (rx_dv_q) begin
      if (!rx_half) begin
        rx_low  <= rx_nib_q;
        rx_half <= 1'b1;
      end else begin
        rx_half   <= 1'b0;
        rx_pend   <= {rx_nib_q, rx_low};
        rx_pend_v <= 1'b1;
      end
    end else begin
      rx_half   <= 1'b0;
      rx_pend_v <= 1'b0;
    end
  end

  always_ff @(posedge mii_receive_clock_in_i or negedge rst_rx_n) begin
    if (!rst_rx_n) begin
      rx_ferr <= 1'b0;
    end else begin
      rx_ferr <= rx_dv_q && (rx_ferr || rx_er_q);
    end
  end

  // PHY cannot be stalled, so a full buffer drops bytes
  always_ff @(posedge mii_receive_clock_in_i or negedge rst_rx_n) begin
    if (!rst_rx_n) begin
      rx_ovf     <= 1'b0;
      rx_ovf_tog <= 1'b0;
    end else begin
      rx_ovf <= rx_dv_q && (rx_ovf || (rx_push && !rx_w.ready));
      // One toggle per frame: drops come faster than mclk_i can see toggles
      if (rx_push && !rx_w.ready && !rx_ovf) begin
        rx_ovf_tog <= ~rx_ovf_tog;
      end
    end
  end

  // One byte held back so the final byte can carry the end mark
  assign rx_push           = rx_pend_v && (!rx_dv_q || rx_half);
  // odd nibble or overflow also errors the frame
  assign rx_push_word      = '{last: !rx_dv_q,
                               err:  !rx_dv_q && (rx_ferr || rx_half || rx_ovf),
                               data: rx_pend};
  assign rx_w.valid        = rx_push;
  assign rx_w.data         = rx_push_word;

  a_rx_byte_pair: assert property (
    @(posedge mii_receive_clock_in_i) disable iff (!rst_rx_n)
    (rx_dv_q && rx_half) |=> rx_pend_v && (rx_pend == {$past(rx_nib_q), $past(rx_low)}))
    else $error("received nibbles not paired low then high");

  a_rx_err_mark: assert property (
    @(posedge mii_receive_clock_in_i) disable iff (!rst_rx_n)
    (rx_dv_q && rx_er_q) ##1 (!rx_dv_q && rx_pend_v) |-> rx_push_word.err)
    else $error("frame with receive error not marked");

  mii_fifo #(.WIDTH(`MII_WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .wr_clk_i     (mii_receive_clock_in_i),
    .wr_reset_n_i (rst_rx_n),
    .rd_clk_i     (mclk_i),
    .rd_reset_n_i (reset_n_i),
    .wr           (rx_w),
    .rd           (rx_r)
  );

  mii_word_t rx_out;

  assign rx_out     = mii_word_t'(rx_r.data);
  assign rx_r.ready = rx_ready_i;
  assign rx_valid_o = rx_r.valid;
  assign rx_data_o  = rx_out.data;
  assign rx_last_o  = rx_out.last;
  assign rx_error_o = rx_out.err;

  // Status on mclk_i: levels through two flops, events by toggle
  logic [3:0] m_sync;
  logic [1:0] ev_prev;
  logic [1:0] ev_pulse;

  mii_sync #(.WIDTH(4)) u_msync (
    .clk_i     (mclk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({mii_carrier_sense_in_i, mii_collision_in_i, tx_under_tog, rx_ovf_tog}),
    .q_o       (m_sync)
  );

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_prev  <= 2'h0;
      ev_pulse <= 2'h0;
    end else begin
      ev_prev  <= m_sync[1:0];
      ev_pulse <= m_sync[1:0] ^ ev_prev;
    end
  end

  assign carrier_sense_o = m_sync[3];
  assign collision_o     = m_sync[2];
  assign tx_underrun_o   = ev_pulse[1];
  assign rx_overflow_o   = ev_pulse[0];

  a_crs_two_stage: assert property (
    @(posedge mclk_i) disable iff (!reset_n_i)
    $rose(carrier_sense_o) |-> $past(mii_carrier_sense_in_i, 2))
    else $error("carrier sense rose without two-stage history");
endmodule : mii_mac_phy_interface

// *** verif/mii_phy_model.sv ***
// PHY stand-in: free-running link clocks, transmit capture, receive frames.
// Assumes the bench fills rx_q before send and reads tx_q and frames.
`timescale 1ns/10ps

module mii_phy_model (
  output logic             tx_clk_o,
  output logic             rx_clk_o,
  input  wire logic        tx_en_i,
  input  wire logic [3:0]  tx_nib_i,
  input  wire logic        tx_er_i,
  output logic             rx_dv_o,
  output logic [3:0]       rx_nib_o,
  output logic             rx_er_o
);
  logic [8:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [3:0] low    = 4'h0;
  logic       half   = 1'b0;
  logic       er_acc = 1'b0;
  logic       en_d   = 1'b0;
  logic       busy   = 1'b0;
  int         frames = 0;
  int         idle_bad = 0;

  initial begin
    tx_clk_o = 1'b0;
    #3.3;
    forever #6 tx_clk_o = ~tx_clk_o;
  end
  initial begin
    rx_clk_o = 1'b0;
    #1.7;
    forever #6 rx_clk_o = ~rx_clk_o;
  end
  initial begin
    rx_dv_o = 1'b0;
    rx_er_o = 1'b0;
    rx_nib_o = 4'h5;
  end

  always @(posedge tx_clk_o) begin
    if (tx_en_i) begin
      er_acc = half ? (er_acc | tx_er_i) : tx_er_i;
      if (half) tx_q.push_back({er_acc, tx_nib_i, low});
      low = tx_nib_i;
      half = !half;
    end else begin
      if (tx_nib_i !== 4'h0 || tx_er_i !== 1'b0) idle_bad++;
      if (half) tx_q.push_back({er_acc, 4'h0, low});
      if (en_d) frames++;
      half = 1'b0;
    end
    en_d = tx_en_i;
  end

  // Idle data never repeats its last value
  always @(posedge rx_clk_o) begin
    if (!busy) rx_nib_o <= ~rx_nib_o;
  end

  task automatic send(input int nnib, input int er_at);
    busy = 1'b1;
    for (int i = 0; i < nnib; i++) begin
      @(posedge rx_clk_o);
      rx_dv_o <= 1'b1;
      rx_nib_o <= i[0] ? rx_q[i/2][7:4] : rx_q[i/2][3:0];
      rx_er_o <= (i == er_at);
    end
    @(posedge rx_clk_o);
    rx_dv_o <= 1'b0;
    rx_er_o <= 1'b0;
    rx_nib_o <= ~rx_nib_o;
    @(posedge rx_clk_o);
    busy = 1'b0;
  endtask : send
endmodule : mii_phy_model

// *** verif/tb_mii_mac_phy_interface.sv ***
// Self-checking bench for the MII MAC-side block against a PHY model.
// Assumes the model owns both link clocks; mclk_i is made here.
`timescale 1ns/10ps

module tb_mii_mac_phy_interface;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic       tx_clk, rx_clk, tx_en, tx_er, rx_dv, rx_er;
  logic [3:0] tx_nib, rx_nib;
  logic       crs = 1'b0, col = 1'b0, rx_ready = 1'b0, stall = 1'b0;
  logic       tx_valid = 1'b0, tx_last = 1'b0, tx_err = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic       tx_ready, rx_valid, rx_last, rx_error, csense, coll, urun_p, oflow_p;
  logic [9:0] got_q[$];
  int         fails = 0, checked = 0, urun = 0, oflow = 0;

  initial begin
    forever #50 mclk = ~mclk;
  end

  mii_mac_phy_interface u_mii_mac_phy_interface (
    .mclk_i(mclk), .reset_n_i(reset_n),
    .mii_transmit_clock_in_i(tx_clk), .mii_receive_clock_in_i(rx_clk),
    .mii_transmit_enable_out_o(tx_en), .mii_transmit_nibble_out_o(tx_nib),
    .mii_transmit_error_out_o(tx_er), .mii_receive_valid_in_i(rx_dv),
    .mii_receive_nibble_in_i(rx_nib), .mii_receive_error_in_i(rx_er),
    .mii_carrier_sense_in_i(crs), .mii_collision_in_i(col),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_error_i(tx_err), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_last_o(rx_last), .rx_error_o(rx_error),
    .rx_ready_i(rx_ready), .carrier_sense_o(csense), .collision_o(coll),
    .tx_underrun_o(urun_p), .rx_overflow_o(oflow_p));

  mii_phy_model u_mii_phy_model (
    .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .tx_en_i(tx_en), .tx_nib_i(tx_nib),
    .tx_er_i(tx_er), .rx_dv_o(rx_dv), .rx_nib_o(rx_nib), .rx_er_o(rx_er));

  // Outputs are settled at the falling edge; the next rising edge takes the word
  always @(negedge mclk) begin
    if (rx_valid === 1'b1 && rx_ready) got_q.push_back({rx_error & rx_last, rx_last, rx_data});
    if (urun_p === 1'b1) urun++;
    if (oflow_p === 1'b1) oflow++;
  end
  always @(posedge mclk) begin
    rx_ready <= stall ? 1'b0 : 1'($urandom_range(1));
  end

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_n(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_n

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : do_reset

  // Each byte is held until tx_ready was seen high before the taking edge
  task automatic tx_frame(input logic [7:0] b[$], input logic [15:0] em);
    logic ok;
    for (int i = 0; i < b.size(); i++) begin
      @(posedge mclk);
      tx_valid <= 1'b1;
      tx_data <= b[i];
      tx_last <= (i == b.size() - 1);
      tx_err <= em[i];
      do begin
        @(negedge mclk);
        ok = tx_ready;
      end while (ok !== 1'b1);
    end
    @(posedge mclk);
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
  endtask : tx_frame

  task automatic wait_for(input int n, input bit rx);
    for (int t = 0; t < 500; t++) begin
      if ((rx ? got_q.size() : u_mii_phy_model.tx_q.size()) >= n) break;
      @(posedge mclk);
    end
    repeat (10) @(posedge mclk);
  endtask : wait_for

  // Error shows on the last byte only: bad nibble count or error while valid
  function automatic logic [9:0] rx_exp(input logic [7:0] b, input int i, input int nn,
                                        input int ea);
    logic last;
    last = (i == nn / 2 - 1);
    return {last & (nn % 2 == 1 || ea >= 0), last, b};
  endfunction : rx_exp

  initial begin
    logic [7:0] b[$];
    logic [7:0] tq[$];
    int nn, ea, f0;
    void'($urandom(29));
    do_reset();
    @(negedge mclk);
    chk("tx enable", 10'h0, 10'(tx_en));
    chk("tx nibble", 10'h0, 10'(tx_nib));
    chk("rx valid", 10'h0, 10'(rx_valid));
    chk("tx ready", 10'h1, 10'(tx_ready));
    $display("test reset done");

    // error nibble after a mid-frame stall
    tq = '{8'h5a, 8'hc3, 8'h0f, 8'h77};
    u_mii_phy_model.tx_q.delete();
    tx_frame(tq, 16'h0001);
    wait_for(2, 0);
    chk("tx first", 10'h15a, {1'b0, u_mii_phy_model.tx_q[0]});
    chk("tx error nibble", 10'h100, {1'b0, u_mii_phy_model.tx_q[1]});
    chk_n("tx kept", 2, u_mii_phy_model.tx_q.size());
    chk_n("underruns", 1, urun);
    $display("test underrun done");

    // buffer full while the reader stalls
    stall = 1'b1;
    b.delete();
    for (int i = 0; i < 20; i++) b.push_back(8'($urandom));
    u_mii_phy_model.rx_q = b;
    got_q.delete();
    u_mii_phy_model.send(40, -1);
    repeat (20) @(posedge mclk);
    chk_n("overflow seen", 1, int'(oflow > 0));
    stall = 1'b0;
    wait_for(16, 1);
    chk_n("rx held", 16, got_q.size());
    for (int i = 0; i < 16; i++) chk("rx kept", {2'b00, b[i]}, got_q[i]);
    @(negedge mclk);
    chk("rx drained", 10'h0, 10'(rx_valid));
    do_reset();
    $display("test overflow done");

    // both directions at once, corners first
    f0 = u_mii_phy_model.frames;
    u_mii_phy_model.idle_bad = 0;
    for (int f = 0; f < 12; f++) begin
      nn = f == 0 ? 7 : f == 1 ? 10 : 2 * (1 + $urandom_range(7));
      ea = f == 1 ? 3 : f == 2 ? 0 : f == 3 ? nn - 1 : -1;
      b.delete();
      for (int i = 0; i < (nn + 1) / 2; i++) b.push_back(8'($urandom));
      u_mii_phy_model.rx_q = b;
      tq = '{8'($urandom)};
      got_q.delete();
      u_mii_phy_model.tx_q.delete();
      fork
        tx_frame(tq, 16'(f % 3 == 1));
        u_mii_phy_model.send(nn, ea);
      join
      wait_for(nn / 2, 1);
      chk_n("rx count", nn / 2, got_q.size());
      for (int i = 0; i < nn / 2; i++) chk("rx word", rx_exp(b[i], i, nn, ea), got_q[i]);
      chk("tx byte", {1'b0, 1'(f % 3 == 1), tq[0]}, {1'b0, u_mii_phy_model.tx_q[0]});
    end
    chk_n("tx frames", 12, u_mii_phy_model.frames - f0);
    chk_n("tx idle", 0, u_mii_phy_model.idle_bad);
    $display("test traffic done");

    for (int v = 0; v < 4; v++) begin
      @(posedge mclk);
      crs <= v[0] | v[1];
      col <= v[1];
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk("carrier", 10'(v[0] | v[1]), 10'(csense));
      chk("collision", 10'(v[1]), 10'(coll));
    end
    $display("test status done");
    summarize();
  end

  initial begin
    #1ms;
    fails++;
    summarize();
  end
endmodule : tb_mii_mac_phy_interface
